/* src/sarrd_pkg.sv */
/*
 package for the sar converter serial readout block.
 assumes a 40 MHz system clock; shift clock and pins arrive asynchronously.
*/
package sarrd_pkg;
   localparam int RESULT_BITS = 16;
   localparam int CLK_MHZ = 40;
   // conversion time, longest figure, in ns
   localparam int CONV_TIME_NS = 3000;
   localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;
   localparam int CONV_CNT_W = 8;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   typedef enum {
      SARRD_SLEEP,
      SARRD_CONVERT,
      SARRD_READY
   } sarrd_state_t;

   // synchronised pin levels
   typedef struct packed {
      logic convert_start;
      logic shift_clock;
      logic chain_select;
      logic read_enable_or_chain_input;
   } sarrd_pins_t;
endpackage

/* src/sarrd_sync.sv */
/*
 two flip-flop synchroniser, one per bit of a pin vector.
 assumes inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sarrd_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         // first stage feeds the second only
         always_ff @(posedge clk) begin
            if (!reset_n) begin
               stage1[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               stage1[i] <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* src/sarrd_top.sv */
/*
 conversion control, busy flag and serial readout of a 16-bit sar converter.
 assumes the host drives convert start, shift clock and the shared enable or
 chain input; all are sampled on clk; shift clock well below clk/4.
*/
`timescale 1ns/1ps
`default_nettype none
module sarrd_top #(
   parameter int CONV_CYCLES = sarrd_pkg::CONV_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic convert_start,
   input wire logic shift_clock,
   input wire logic chain_select,
   input wire logic read_enable_or_chain_input,
   input wire logic [15:0] sample_code,
   output logic busy,
   output logic serial_out,
   output logic serial_out_en_n,
   output logic chain_mode,
   output logic powered_up
);
   sarrd_pkg::sarrd_pins_t pins;
   sarrd_pkg::sarrd_state_t state;
   logic conv_prev;
   logic sck_prev;
   logic conv_rise;
   logic sck_rise;
   logic [sarrd_pkg::CONV_CNT_W-1:0] conv_cnt;
   logic [15:0] shift_reg;
   logic conv_done;

   sarrd_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .async_in({convert_start, shift_clock, chain_select,
                 read_enable_or_chain_input}),
      .sync_out(pins)
   );

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         conv_prev <= 1'b0;
         sck_prev <= 1'b0;
      end else begin
         conv_prev <= pins.convert_start;
         sck_prev <= pins.shift_clock;
      end
   end

   assign conv_rise = pins.convert_start && !conv_prev;
   assign sck_rise = pins.shift_clock && !sck_prev;
   assign conv_done = (state == sarrd_pkg::SARRD_CONVERT) &&
      (conv_cnt == sarrd_pkg::CONV_CNT_W'(CONV_CYCLES - 1));

   // wake and convert; a new edge mid-conversion is ignored
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= sarrd_pkg::SARRD_SLEEP;
         conv_cnt <= '0;
      end else begin
         case (state)
            sarrd_pkg::SARRD_SLEEP,
            sarrd_pkg::SARRD_READY: begin
               conv_cnt <= '0;
               if (conv_rise) begin
                  state <= sarrd_pkg::SARRD_CONVERT;
               end
            end
            sarrd_pkg::SARRD_CONVERT: begin
               conv_cnt <= conv_cnt + 1'b1;
               if (conv_done) begin
                  state <= sarrd_pkg::SARRD_READY;
               end
            end
            default: begin
               state <= sarrd_pkg::SARRD_SLEEP;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         busy <= 1'b0;
      end else if (conv_rise && state != sarrd_pkg::SARRD_CONVERT) begin
         busy <= 1'b1;
      end else if (conv_done) begin
         busy <= 1'b0;
      end
   end

   // powered down between conversions, awake while converting
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         powered_up <= 1'b0;
      end else begin
         powered_up <= (state == sarrd_pkg::SARRD_CONVERT);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         chain_mode <= 1'b0;
      end else begin
         chain_mode <= pins.chain_select;
      end
   end

   // load result; unsigned binary, no recoding
   // shift msb first; chain data enters at the lsb
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         shift_reg <= sarrd_pkg::RESULT_RESET;
      end else if (conv_done) begin
         shift_reg <= sample_code;
      end else if (sck_rise && (pins.chain_select ||
                   !pins.read_enable_or_chain_input)) begin
         // shared pin is chain data in chain mode
         shift_reg <= {shift_reg[14:0],
                       pins.chain_select &
                       pins.read_enable_or_chain_input};
      end
   end

   // msb comes out together with the busy fall
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         serial_out <= 1'b0;
      end else if (conv_done) begin
         serial_out <= sample_code[15];
      end else begin
         serial_out <= shift_reg[15];
      end
   end

   // enable from shared pin in normal mode; chain always drives
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         serial_out_en_n <= 1'b1;
      end else begin
         serial_out_en_n <= !pins.chain_select &&
                            pins.read_enable_or_chain_input;
      end
   end

   AST_MSB_AT_BUSY_FALL: assert property (
      @(posedge clk) disable iff (!reset_n)
      $fell(busy) |-> serial_out == $past(sample_code[15]))
      else $error("msb not on output at busy fall");

   sequence s_start;
      $rose(busy);
   endsequence
   AST_BUSY_LENGTH: assert property (
      @(posedge clk) disable iff (!reset_n)
      s_start |-> busy [*8])
      else $error("busy fell too early");

   AST_START_BUSY: assert property (
      @(posedge clk) disable iff (!reset_n)
      (conv_rise && !busy) |=> busy)
      else $error("start edge did not raise busy");

   // shift moves the word by one
   AST_SHIFT_ONE: assert property (
      @(posedge clk) disable iff (!reset_n)
      (sck_rise && !conv_done && !pins.chain_select &&
       !pins.read_enable_or_chain_input) |=>
      shift_reg[15:1] == $past(shift_reg[14:0]))
      else $error("shift did not advance one bit");

   AST_CHAIN_IN: assert property (
      @(posedge clk) disable iff (!reset_n)
      (sck_rise && !conv_done && pins.chain_select) |=>
      shift_reg[0] == $past(pins.read_enable_or_chain_input))
      else $error("chain data lost");

   // released when enable high in normal mode
   AST_RELEASE: assert property (
      @(posedge clk) disable iff (!reset_n)
      (!pins.chain_select && pins.read_enable_or_chain_input) |=>
      serial_out_en_n)
      else $error("output not released");

   AST_DRIVE: assert property (
      @(posedge clk) disable iff (!reset_n)
      (!pins.chain_select && !pins.read_enable_or_chain_input) |=>
      !serial_out_en_n)
      else $error("output not driven");

   AST_CHAIN_DRIVE: assert property (
      @(posedge clk) disable iff (!reset_n)
      pins.chain_select |=> !serial_out_en_n)
      else $error("chain mode not driving");

   AST_LOAD: assert property (
      @(posedge clk) disable iff (!reset_n)
      conv_done |=> shift_reg == $past(sample_code))
      else $error("result not loaded");
endmodule
`default_nettype wire

/* bench/sarrd_host.sv */
/*
 host controller model: starts conversions, clocks the serial output.
 assumes clk is the 40 MHz bench clock; shift clock period is 8 clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sarrd_host (
   input wire logic clk,
   input wire logic busy,
   input wire logic sdo,
   output logic convert_start,
   output logic shift_clock,
   output logic rd_n,
   output logic [31:0] word
);
   initial begin
      convert_start = 1'b0;
      shift_clock = 1'b0;
      rd_n = 1'b1;
      word = 32'h0000_0000;
   end
   // rising edge starts, then bounded wait
   task automatic convert(output int cyc);
      int n;
      begin
         cyc = 0;
         n = 0;
         @(posedge clk) convert_start <= 1'b1;
         repeat (6) @(posedge clk);
         convert_start <= 1'b0;
         #1;
         while (busy === 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            cyc++;
            n++;
         end
      end
   endtask
   task automatic shift(input int nb);
      for (int i = 0; i < nb; i++) begin
         @(posedge clk) shift_clock <= 1'b1;
         word <= {word[30:0], sdo};
         repeat (4) @(posedge clk);
         shift_clock <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic enable(input logic v);
      @(posedge clk) rd_n <= v;
      repeat (5) @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

/* bench/sarrd_top_tb_top.sv */
/*
 self-checking bench for the serial readout block.
 assumes the host model drives the pins; small conversion count.
*/
`timescale 1ns/1ps
`default_nettype none
module sarrd_top_tb_top;
   localparam int CONV = 8;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic chain_sel = 1'b0;
   logic chain_d = 1'b1;
   logic [15:0] code = 16'h0000;
   logic [31:0] seed = 32'h70b6;
   logic busy, sout, en_n, cmode, cs, sck, rdn, pwr;
   logic sdo_last = 1'b0;
   logic [31:0] word;
   int miscompares = 0;
   int n_checks = 0;
   int cyc;
   int b0;
   int busy_cyc = 0;
   int pwr_cyc = 0;
   // released line shows inverse of last driven bit
   wire sdo = en_n ? ~sdo_last : sout;
   always @(posedge clk) if (!en_n) sdo_last <= sout;
   // high cycles of busy and power, for length checks
   always @(posedge clk) begin
      if (busy === 1'b1) busy_cyc++;
      if (pwr === 1'b1) pwr_cyc++;
   end
   initial forever #12.5 clk = ~clk;
   sarrd_top #(.CONV_CYCLES(CONV)) u_dut (.clk(clk), .reset_n(reset_n),
      .convert_start(cs), .shift_clock(sck), .chain_select(chain_sel),
      .read_enable_or_chain_input(chain_sel ? chain_d : rdn),
      .sample_code(code), .busy(busy), .serial_out(sout),
      .serial_out_en_n(en_n), .chain_mode(cmode), .powered_up(pwr));
   sarrd_host u_host (.clk(clk), .busy(busy), .sdo(sdo),
      .convert_start(cs), .shift_clock(sck), .rd_n(rdn), .word(word));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [19:0] chain_exp(input logic [15:0] c,
                                             input logic d);
      return {c, {4{d}}};
   endfunction
   task automatic check(input string what, input logic [31:0] exp, got);
      n_checks++;
      if (exp !== got) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      test_done;
   end
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         @(posedge clk) code <= (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 :
                                (i == 2) ? 16'h8001 : seed[15:0];
         b0 = busy_cyc;
         u_host.convert(cyc);
         check("busy_len", CONV, busy_cyc - b0);
         check("msb_busy_fall", 32'(code[15]), sout);
         check("busy_len_lo", 1, cyc >= CONV - 4);
         check("busy_len_hi", 1, cyc <= CONV + 2);
         // shifts with enable high are ignored
         if (i == 3) u_host.shift(4);
         u_host.enable(1'b0);
         check("en_n_low", 32'h0, en_n);
         u_host.shift(16);
         check("word", code, word[15:0]);
         u_host.enable(1'b1);
         check("en_n_high", 32'h1, en_n);
      end
      @(posedge clk) chain_sel <= 1'b1;
      code <= 16'ha5c3;
      repeat (4) @(posedge clk);
      check("chain_mode", 32'h1, cmode);
      // second frame with upstream zeros, so a stuck chain bit shows
      for (int k = 0; k < 2; k++) begin
         b0 = busy_cyc;
         u_host.convert(cyc);
         check("chain_busy_len", CONV, busy_cyc - b0);
         u_host.shift(20);
         check("chain_word", chain_exp(code, chain_d), word[19:0]);
         seed = lfsr(seed);
         @(posedge clk) code <= seed[15:0];
         chain_d <= 1'b0;
      end
      check("powered", 10 * CONV, pwr_cyc);
      test_done;
   end
endmodule
`default_nettype wire
